// ==== shared/humid_pkg.sv ====
// Shared constants and types for the humidity alert device and its link master.
package humid_pkg;
  // ==========================================================================
  // Timing.
  localparam int CLK_NS       = 25;
  localparam int STRETCH_NS   = 10000;
  localparam int STRETCH_CYC  = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SOFT_GAP_MS  = 500;
  localparam int SOFT_GAP_CYC = (SOFT_GAP_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int SCL_HZ       = 100000;
  localparam int SCL_Q_CYC    = 1000000000 / (SCL_HZ * 4) / CLK_NS;
  // ==========================================================================
  // Data formats.
  localparam int HUM_W     = 14;
  localparam int BYTE_BITS = 8;
  localparam int ID_BYTES  = 4;
  localparam int THR_N     = 8;
  localparam int EN_W      = 4;
  localparam logic [7:0] HI_MASK = 8'h3f;
  localparam logic [7:0] LO_MASK = 8'hff;
  // ==========================================================================
  // Commands.
  localparam logic [7:0] CMD_FETCH_ID   = 8'hd7;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hfe;
  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] REG_ALERT_POL           = 8'h02;
  localparam logic [7:0] REG_ALERT_EN            = 8'h03;
  localparam logic [7:0] REG_HUM_HIGH_RELEASE_LO = 8'h0d;
  localparam logic [7:0] REG_HUM_HIGH_RELEASE_HI = 8'h0e;
  localparam logic [7:0] REG_HUM_HIGH_TRIGGER_LO = 8'h0f;
  localparam logic [7:0] REG_HUM_HIGH_TRIGGER_HI = 8'h10;
  localparam logic [7:0] REG_HUM_LOW_TRIGGER_LO  = 8'h11;
  localparam logic [7:0] REG_HUM_LOW_TRIGGER_HI  = 8'h12;
  localparam logic [7:0] REG_HUM_LOW_RELEASE_LO  = 8'h13;
  localparam logic [7:0] REG_HUM_LOW_RELEASE_HI  = 8'h14;
  // ==========================================================================
  // Fields and reset values.
  localparam int POL_BIT     = 0;
  localparam int EN_HUM_LOW  = 0;
  localparam int EN_HUM_HIGH = 1;
  localparam logic            POL_DEF = 1'b1;
  localparam logic [EN_W-1:0] EN_DEF  = 4'h0;
  // Byte i of the threshold block sits at bits 8*i+7:8*i.
  localparam logic [63:0]     THR_DEF = 64'h0000_0000_3fff_3fff;
  // ==========================================================================
  // Master operations.
  typedef enum logic [1:0] {OP_WRITE_REG, OP_READ_REG, OP_FETCH_ID, OP_SOFT_RESET} op_t;
endpackage

// ==== shared/humid_link_if.sv ====
// Two-wire open-drain link joining the humidity device and its master.
`timescale 1ns/10ps
interface humid_link_if;
  logic scl;
  logic sda;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;

  // Wired-AND with pull-ups: a line is low only while some end drives low.
  assign scl = (dev_scl_oe_n | dev_scl_o) & (host_scl_oe_n | host_scl_o);
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);

  modport dev  (input scl, sda, output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n);
  modport host (input scl, sda, output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n);
endinterface

// ==== hdl/humid_alert_dev.sv ====
// Humidity sensor digital core: alert thresholds, serial readout and soft reset.
`timescale 1ns/10ps
// Overview of operation
// RULE1 - High alert when humidity exceeds trigger level
// RULE2 - High alert clears when humidity below release
// RULE3 - Low alert when humidity under trigger level
// RULE4 - Low alert clears when humidity above release
// RULE5 - Thresholds 14 bits, upper byte top two zero
// RULE6 - Compare thresholds in measurement's own code
// RULE7 - Hold a unique 32-bit identifier
// RULE8 - Master wakes device with write address first
// RULE9 - Master sends 0xd7 then repeated read address
// RULE10 - Stretch clock about 10 us fetching identifier
// RULE11 - Identifier goes out four bytes, MSB first
// RULE12 - Command 0xfe restores writable registers
// RULE13 - Master reads pending result before soft reset; humid_alert_host sends 0xfe on request and leaves this to the user
// RULE14 - Master halts repeat sampling before soft reset; humid_alert_host sends 0xfe on request and leaves this to the user
// RULE15 - Master stays silent 500 ms after soft reset
// RULE16 - After soft reset behave as after power-up
// RULE17 - Each alert evaluated only when enabled
// RULE18 - Alert pin active high by default, else low
// RULE19 - Alerts latched, re-evaluated per finished measurement
module humid_alert_dev #(
  parameter logic [6:0]  DEV_ADDR  = 7'h44,         // Arbitrary bus address.
  parameter logic [31:0] UNIQUE_ID = 32'h5a5a_0001  // Arbitrary identifier value.
) (
  // Clock and reset.
  input  wire logic                       I_MCLK,
  input  wire logic                       I_RST,
  // Measurement results.
  input  wire logic [humid_pkg::HUM_W-1:0] I_HUMIDITY_READING,
  input  wire logic                       I_MEAS_DONE,
  // Alert pin.
  output logic                            O_ALERT,
  // Serial link.
  humid_link_if.dev                       LINK
);
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_WBYTE, S_WACK, S_STRETCH, S_RBYTE, S_RACK
  } dev_state_t;

  localparam int STR_W = $clog2(humid_pkg::STRETCH_CYC + 1);

  dev_state_t                   state;
  logic [3:0]                   cnt;
  logic [7:0]                   sh;
  logic                         rnw;
  logic                         first;
  logic [7:0]                   ptr;
  logic                         id_mode;
  logic [STR_W-1:0]             scnt;
  logic                         scl_oe_n;
  logic                         sda_oe_n;
  logic                         scl_q;
  logic                         sda_q;
  logic [7:0]                   thr [humid_pkg::THR_N];
  logic                         pol;
  logic [humid_pkg::EN_W-1:0]   en;
  logic                         hi_on;
  logic                         lo_on;

  // ==========================================================================
  // Helpers.
  // Join an upper and lower threshold byte into the measurement code.
  function automatic logic [humid_pkg::HUM_W-1:0] pair(input logic [7:0] hi,
                                                       input logic [7:0] lo);
    pair = {hi[5:0], lo}; // [RULE5] [RULE6]
  endfunction

  // Pick one identifier byte, most significant first.
  function automatic logic [7:0] id_byte(input logic [7:0] idx);
    id_byte = UNIQUE_ID[8 * (3 - int'(idx[1:0])) +: 8]; // [RULE11]
  endfunction

  // ==========================================================================
  // Line events, sampled on the system clock.
  wire scl_rise = LINK.scl & ~scl_q;
  wire scl_fall = ~LINK.scl & scl_q;
  wire start_c  = scl_q & LINK.scl & sda_q & ~LINK.sda;
  wire stop_c   = scl_q & LINK.scl & ~sda_q & LINK.sda;
  wire byte_end = scl_fall && cnt == 4'(humid_pkg::BYTE_BITS);
  wire wr_byte  = state == S_WBYTE && byte_end && !start_c && !stop_c;
  wire wr_en    = wr_byte && !first;
  wire soft_rst = wr_byte && first && sh == humid_pkg::CMD_SOFT_RESET; // [RULE12]
  wire clr      = I_RST | soft_rst; // [RULE16]

  // Register decode and read data.
  wire            thr_hit = ptr >= humid_pkg::REG_HUM_HIGH_RELEASE_LO &&
                            ptr <= humid_pkg::REG_HUM_LOW_RELEASE_HI;
  wire [2:0]      thr_idx = 3'(ptr - humid_pkg::REG_HUM_HIGH_RELEASE_LO);
  wire [7:0]      reg_rd  = ptr == humid_pkg::REG_ALERT_POL ? {7'h00, pol} :
                            ptr == humid_pkg::REG_ALERT_EN  ? {4'h0, en} :
                            thr_hit                         ? thr[thr_idx] : 8'h00;
  wire [7:0]      id_rd   = ptr < 8'(humid_pkg::ID_BYTES) ? id_byte(ptr) : 8'h00;
  wire [7:0]      rd_byte = id_mode ? id_rd : reg_rd; // [RULE7]

  // Threshold pairs in the same 14-bit code as the measurement.
  wire [humid_pkg::HUM_W-1:0] hi_rel  = pair(thr[1], thr[0]); // [RULE2]
  wire [humid_pkg::HUM_W-1:0] hi_trig = pair(thr[3], thr[2]); // [RULE1]
  wire [humid_pkg::HUM_W-1:0] lo_trig = pair(thr[5], thr[4]); // [RULE3]
  wire [humid_pkg::HUM_W-1:0] lo_rel  = pair(thr[7], thr[6]); // [RULE4]

  // Next alert flags: held between measurements, dropped when disabled.
  wire next_hi = !en[humid_pkg::EN_HUM_HIGH] ? 1'b0 :                 // [RULE17]
                 !I_MEAS_DONE ? hi_on :                               // [RULE19]
                 hi_on ? !(I_HUMIDITY_READING < hi_rel) :             // [RULE2]
                 I_HUMIDITY_READING > hi_trig;                        // [RULE1]
  wire next_lo = !en[humid_pkg::EN_HUM_LOW] ? 1'b0 :                  // [RULE17]
                 !I_MEAS_DONE ? lo_on :                               // [RULE19]
                 lo_on ? !(I_HUMIDITY_READING > lo_rel) :             // [RULE4]
                 I_HUMIDITY_READING < lo_trig;                        // [RULE3]
  wire next_alert = (next_hi | next_lo) ~^ pol; // [RULE18]

  // Open-drain pins only ever pull low.
  assign LINK.dev_scl_o    = 1'b0;
  assign LINK.dev_sda_o    = 1'b0;
  assign LINK.dev_scl_oe_n = scl_oe_n;
  assign LINK.dev_sda_oe_n = sda_oe_n;

  // ==========================================================================
  // Previous line levels for edge and condition detection.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= LINK.scl;
      sda_q <= LINK.sda;
    end
  end

  // ==========================================================================
  // Serial slave. Bits are taken on SCL rise and changed on SCL fall.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      state    <= S_IDLE;
      cnt      <= 4'h0;
      sh       <= 8'h00;
      rnw      <= 1'b0;
      first    <= 1'b0;
      ptr      <= 8'h00;
      id_mode  <= 1'b0;
      scnt     <= '0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (start_c) begin
      // A repeated start keeps the pointer and a pending identifier fetch.
      state    <= S_ADDR;
      cnt      <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_c) begin
      state    <= S_IDLE;
      sda_oe_n <= 1'b1;
      id_mode  <= 1'b0;
    end else begin
      case (state)
        S_ADDR, S_WBYTE: begin
          if (scl_rise) begin
            sh  <= {sh[6:0], LINK.sda};
            cnt <= 4'(cnt + 1);
          end else if (byte_end && state == S_ADDR) begin
            if (sh[7:1] == DEV_ADDR) begin
              sda_oe_n <= 1'b0;
              rnw      <= sh[0];
              state    <= S_AACK;
            end else begin
              state <= S_IDLE;
            end
          end else if (byte_end) begin
            sda_oe_n <= 1'b0;
            state    <= S_WACK;
            first    <= 1'b0;
            if (!first) begin
              ptr <= 8'(ptr + 1);
            end else if (sh == humid_pkg::CMD_FETCH_ID) begin
              id_mode <= 1'b1;
            end else if (sh == humid_pkg::CMD_SOFT_RESET) begin
              ptr     <= 8'h00; // [RULE16]
              id_mode <= 1'b0;
            end else begin
              ptr <= sh;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            cnt      <= 4'h0;
            if (!rnw) begin
              first <= 1'b1;
              state <= S_WBYTE;
            end else if (id_mode) begin
              // Hold SCL so the master cannot clock before the ID is ready.
              scl_oe_n <= 1'b0; // [RULE10]
              scnt     <= STR_W'(humid_pkg::STRETCH_CYC - 1);
              ptr      <= 8'h00;
              state    <= S_STRETCH;
            end else begin
              sh       <= rd_byte;
              sda_oe_n <= rd_byte[7];
              state    <= S_RBYTE;
            end
          end
        end
        S_WACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            cnt      <= 4'h0;
            state    <= S_WBYTE;
          end
        end
        S_STRETCH: begin
          // Set the first bit up under the held clock so it is stable before SCL rises.
          sh       <= rd_byte;
          sda_oe_n <= rd_byte[7]; // [RULE11]
          if (scnt == '0) begin
            scl_oe_n <= 1'b1; // [RULE10]
            state    <= S_RBYTE;
          end else begin
            scnt <= STR_W'(scnt - 1);
          end
        end
        S_RBYTE: begin
          if (scl_rise) begin
            cnt <= 4'(cnt + 1);
          end else if (byte_end) begin
            sda_oe_n <= 1'b1;
            state    <= S_RACK;
          end else if (scl_fall) begin
            sh       <= {sh[6:0], 1'b0};
            sda_oe_n <= sh[6]; // [RULE11]
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            if (LINK.sda) begin
              state <= S_IDLE;
            end else begin
              ptr <= 8'(ptr + 1);
            end
          end else if (scl_fall) begin
            sh       <= rd_byte;
            sda_oe_n <= rd_byte[7];
            cnt      <= 4'h0;
            state    <= S_RBYTE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Writable registers; soft reset restores the power-up values.
  always_ff @(posedge I_MCLK) begin
    if (clr) begin
      for (int i = 0; i < humid_pkg::THR_N; i++) begin
        thr[i] <= humid_pkg::THR_DEF[8 * i +: 8]; // [RULE12]
      end
      pol <= humid_pkg::POL_DEF;
      en  <= humid_pkg::EN_DEF;
    end else if (wr_en) begin
      if (ptr == humid_pkg::REG_ALERT_POL) begin
        pol <= sh[humid_pkg::POL_BIT];
      end else if (ptr == humid_pkg::REG_ALERT_EN) begin
        en <= sh[humid_pkg::EN_W-1:0];
      end else if (thr_hit) begin
        // Upper bytes keep their two top bits at zero.
        thr[thr_idx] <= sh & (thr_idx[0] ? humid_pkg::HI_MASK : humid_pkg::LO_MASK); // [RULE5]
      end
    end
  end

  // ==========================================================================
  // Alert latches and pin. Reset leaves the pin idle for the default polarity.
  always_ff @(posedge I_MCLK) begin
    if (clr) begin
      hi_on   <= 1'b0;
      lo_on   <= 1'b0;
      O_ALERT <= 1'b0;
    end else begin
      hi_on   <= next_hi;
      lo_on   <= next_lo;
      O_ALERT <= next_alert; // [RULE18]
    end
  end
endmodule // humid_alert_dev

// ==== hdl/humid_alert_host.sv ====
// Link master that writes and reads the sensor registers, its ID and soft reset.
`timescale 1ns/10ps
module humid_alert_host #(
  parameter int         SCL_Q_CYC = humid_pkg::SCL_Q_CYC,
  parameter int         GAP_CYC   = humid_pkg::SOFT_GAP_CYC,
  parameter logic [6:0] DEV_ADDR  = 7'h44  // Arbitrary bus address.
) (
  // Clock and reset.
  input  wire logic             I_MCLK,
  input  wire logic             I_RST,
  // Request port.
  input  wire logic             I_REQ,
  input  wire humid_pkg::op_t   I_OP,
  input  wire logic [7:0]       I_REG_ADDR,
  input  wire logic [7:0]       I_WDATA,
  // Answer port.
  output logic                  O_BUSY,
  output logic                  O_DONE,
  output logic                  O_NACK,
  output logic [31:0]           O_RDATA,
  // Serial link.
  humid_link_if.host            LINK
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_GAP} host_state_t;
  typedef enum logic [2:0] {G_ADDRW, G_CMD, G_DATA, G_ADDRR, G_READ} seg_t;

  localparam int QW = $clog2(SCL_Q_CYC + 1);
  localparam int GW = $clog2(GAP_CYC + 1);

  // Elaboration check on the timing parameters.
  if (SCL_Q_CYC < 1 || GAP_CYC < 1) begin : g_bad_param
    $error("Timing parameters must be at least one cycle.");
  end

  host_state_t     state;
  seg_t            seg;
  humid_pkg::op_t  op;
  logic [1:0]      phase;
  logic [QW-1:0]   qcnt;
  logic [GW-1:0]   gap;
  logic [3:0]      bitn;
  logic [8:0]      tx;
  logic [8:0]      rx;
  logic [2:0]      nread;
  logic [7:0]      cmd;
  logic [7:0]      wdata;
  logic            scl_oe_n;
  logic            sda_oe_n;

  // ==========================================================================
  // Quarter-bit tick; phase 2 waits while the device stretches SCL.
  wire tick = qcnt == '0;
  wire adv  = tick && !(phase == 2'd2 && !LINK.scl);
  wire last = bitn == 4'(humid_pkg::BYTE_BITS);
  wire [7:0] req_cmd = I_OP == humid_pkg::OP_FETCH_ID   ? humid_pkg::CMD_FETCH_ID :   // [RULE9]
                       I_OP == humid_pkg::OP_SOFT_RESET ? humid_pkg::CMD_SOFT_RESET :
                       I_REG_ADDR;
  wire [2:0] req_n   = I_OP == humid_pkg::OP_FETCH_ID ? 3'(humid_pkg::ID_BYTES) : 3'd1;

  assign LINK.host_scl_o    = 1'b0;
  assign LINK.host_sda_o    = 1'b0;
  assign LINK.host_scl_oe_n = scl_oe_n;
  assign LINK.host_sda_oe_n = sda_oe_n;

  // Quarter-period divider, free running.
  always_ff @(posedge I_MCLK) begin
    if (I_RST || tick) begin
      qcnt <= QW'(SCL_Q_CYC - 1);
    end else begin
      qcnt <= QW'(qcnt - 1);
    end
  end

  // ==========================================================================
  // Transaction sequencer: start, bytes with acknowledge, stop, quiet gap.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      state    <= H_IDLE;
      seg      <= G_ADDRW;
      op       <= humid_pkg::OP_WRITE_REG;
      phase    <= 2'd0;
      gap      <= '0;
      bitn     <= 4'h0;
      tx       <= 9'h1ff;
      rx       <= 9'h000;
      nread    <= 3'd0;
      cmd      <= 8'h00;
      wdata    <= 8'h00;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      O_BUSY   <= 1'b0;
      O_DONE   <= 1'b0;
      O_NACK   <= 1'b0;
      O_RDATA  <= 32'h0000_0000;
    end else begin
      O_DONE <= 1'b0;
      case (state)
        H_IDLE: begin
          // Only one request at a time; sequencing of measurements is the user's.
          if (I_REQ) begin // [RULE13] [RULE14]
            op      <= I_OP;
            cmd     <= req_cmd;
            wdata   <= I_WDATA;
            nread   <= req_n;
            seg     <= G_ADDRW; // [RULE8]
            phase   <= 2'd0;
            O_BUSY  <= 1'b1;
            O_NACK  <= 1'b0;
            O_RDATA <= 32'h0000_0000;
            state   <= H_START;
          end
        end
        H_START: begin
          if (adv) begin
            phase <= 2'(phase + 1);
            case (phase)
              2'd0: sda_oe_n <= 1'b1;
              2'd1: scl_oe_n <= 1'b1;
              2'd2: sda_oe_n <= 1'b0;
              default: begin
                scl_oe_n <= 1'b0;
                tx       <= {DEV_ADDR, seg == G_ADDRR, 1'b1}; // [RULE8] [RULE9]
                bitn     <= 4'h0;
                state    <= H_BIT;
              end
            endcase
          end
        end
        H_BIT: begin
          if (adv) begin
            phase <= 2'(phase + 1);
            case (phase)
              2'd0: sda_oe_n <= tx[8];
              2'd1: scl_oe_n <= 1'b1;
              2'd2: rx <= {rx[7:0], LINK.sda};
              default: begin
                scl_oe_n <= 1'b0;
                tx       <= {tx[7:0], 1'b1};
                bitn     <= 4'(bitn + 1);
                if (last) begin
                  bitn <= 4'h0;
                  if (seg != G_READ && rx[0]) begin
                    O_NACK <= 1'b1;
                    state  <= H_STOP;
                  end else begin
                    case (seg)
                      G_ADDRW: begin
                        seg <= G_CMD;
                        tx  <= {cmd, 1'b1};
                      end
                      G_CMD: begin
                        if (op == humid_pkg::OP_WRITE_REG) begin
                          seg <= G_DATA;
                          tx  <= {wdata, 1'b1};
                        end else if (op == humid_pkg::OP_SOFT_RESET) begin
                          state <= H_STOP;
                        end else begin
                          seg   <= G_ADDRR; // [RULE9]
                          state <= H_START;
                        end
                      end
                      G_ADDRR: begin
                        seg <= G_READ;
                        tx  <= {8'hff, nread == 3'd1};
                      end
                      G_READ: begin
                        O_RDATA <= {O_RDATA[23:0], rx[8:1]};
                        nread   <= 3'(nread - 1);
                        tx      <= {8'hff, nread == 3'd2};
                        if (nread == 3'd1) begin
                          state <= H_STOP;
                        end
                      end
                      default: state <= H_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (adv) begin
            phase <= 2'(phase + 1);
            case (phase)
              2'd0: sda_oe_n <= 1'b0;
              2'd1: scl_oe_n <= 1'b1;
              2'd2: sda_oe_n <= 1'b1;
              default: begin
                if (op == humid_pkg::OP_SOFT_RESET && !O_NACK) begin
                  gap   <= GW'(GAP_CYC - 1);
                  state <= H_GAP;
                end else begin
                  O_BUSY <= 1'b0;
                  O_DONE <= 1'b1;
                  state  <= H_IDLE;
                end
              end
            endcase
          end
        end
        H_GAP: begin
          if (gap == '0) begin
            O_BUSY <= 1'b0; // [RULE15]
            O_DONE <= 1'b1;
            state  <= H_IDLE;
          end else begin
            gap <= GW'(gap - 1);
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule // humid_alert_host

// ==== dv/humid_link_props.sv ====
// Link checker for the humidity device and its master.
`timescale 1ns/10ps
module humid_link_props (
  // Clock, reset and line levels.
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic scl,
  input wire logic sda,
  // Drive controls of both ends.
  input wire logic dev_scl_o,
  input wire logic dev_sda_o,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_oe_n
);
  default clocking cb @(posedge I_MCLK); endclocking
  // Counts how long the device holds the clock; the 10-bit count wraps, and the upper bound check catches a hold that never ends.
  logic [9:0] low_cnt;
  always_ff @(posedge I_MCLK) begin
    if (I_RST || dev_scl_oe_n) low_cnt <= 10'h000;
    else low_cnt <= low_cnt + 10'h001;
  end
  dev_rst_a: assert property (I_RST |=> dev_scl_oe_n && dev_sda_oe_n)
    else $error("device drives link after reset");
  host_rst_a: assert property (I_RST |=> host_scl_oe_n && host_sda_oe_n)
    else $error("master drives link after reset");
  stretch_min_a: assert property (disable iff (I_RST) $rose(dev_scl_oe_n) |-> low_cnt >= 10'h186)
    else $error("clock hold too short");
  stretch_max_a: assert property (disable iff (I_RST) !dev_scl_oe_n |-> low_cnt <= 10'h19a)
    else $error("clock hold too long");
  stretch_low_a: assert property (disable iff (I_RST) $fell(dev_scl_oe_n) |-> !$past(scl))
    else $error("clock grabbed while high");
  dev_data_a: assert property (disable iff (I_RST) $changed(dev_sda_oe_n) |-> !scl)
    else $error("device data moved while clock high");
  host_start_a: assert property (disable iff (I_RST) $fell(sda) && scl |-> !host_sda_oe_n)
    else $error("start not made by master");
  pull_low_a: assert property (disable iff (I_RST) dev_scl_o == 1'b0 && dev_sda_o == 1'b0)
    else $error("device drives a line high");
endmodule // humid_link_props

// ==== dv/tb_humid_alert_id_reset_logic.sv ====
// Testbench joining the humidity device to its master over the shared link.
`timescale 1ns/10ps
module tb_humid_alert_id_reset_logic;
  localparam logic [31:0] ID = 32'h1357_9bdf;  // Arbitrary identifier value.
  // Rows: offset, write value, read-back, reading, expected alert pin.
  localparam logic [43:0] ROWS [19] = '{
    44'h0d_80_80_3000_0, 44'h0e_00_00_3000_0, 44'h0f_00_00_3000_0, 44'h10_c1_01_3000_0,
    44'h11_20_20_0000_0, 44'h12_00_00_0000_0, 44'h13_40_40_0000_0, 44'h14_c0_00_0000_0,
    44'h20_55_00_0000_0, 44'h03_03_03_0100_0, 44'h03_03_03_0101_1, 44'h03_03_03_0080_1,
    44'h03_03_03_007f_0, 44'h03_03_03_0020_0, 44'h03_03_03_001f_1, 44'h03_03_03_0040_1,
    44'h03_03_03_0041_0, 44'h03_01_01_3000_0, 44'h02_00_00_3000_1};
  logic           clk, rst, req, mdone, alert, busy, done, nack;
  logic [13:0]    hum;
  logic [7:0]     ra, wd;
  logic [31:0]    rdata;
  humid_pkg::op_t op;
  int             err_count = 0;
  int             n_tests = 0;
  humid_link_if lnk ();
  humid_alert_dev #(.UNIQUE_ID(ID)) humid_alert_dev_i (.I_MCLK(clk), .I_RST(rst),
    .I_HUMIDITY_READING(hum), .I_MEAS_DONE(mdone), .O_ALERT(alert), .LINK(lnk.dev));
  humid_alert_host #(.SCL_Q_CYC(4), .GAP_CYC(50)) humid_alert_host_i (.I_MCLK(clk),
    .I_RST(rst), .I_REQ(req), .I_OP(op), .I_REG_ADDR(ra), .I_WDATA(wd), .O_BUSY(busy),
    .O_DONE(done), .O_NACK(nack), .O_RDATA(rdata), .LINK(lnk.host));
  humid_link_props humid_link_props_i (.I_MCLK(clk), .I_RST(rst), .scl(lnk.scl),
    .sda(lnk.sda), .dev_scl_o(lnk.dev_scl_o), .dev_sda_o(lnk.dev_sda_o),
    .dev_scl_oe_n(lnk.dev_scl_oe_n), .dev_sda_oe_n(lnk.dev_sda_oe_n),
    .host_scl_oe_n(lnk.host_scl_oe_n), .host_sda_oe_n(lnk.host_sda_oe_n));
  // ==========================================================================
  // Helpers.
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One request pulse, then wait for the done pulse; the bound only guards a hang.
  task automatic run(humid_pkg::op_t o, logic [7:0] a, logic [7:0] d);
    int n = 0;
    @(posedge clk);
    #1 req = 1'b1; op = o; ra = a; wd = d;
    @(posedge clk);
    #1 req = 1'b0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1 n++;
    end
    chk({busy, done}, 2'b01);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    run(humid_pkg::OP_READ_REG, a, 8'h00);
    chk(rdata, {24'h000000, exp});
  endtask
  task automatic meas(logic [13:0] v);
    @(posedge clk);
    #1 mdone = 1'b1; hum = v;
    @(posedge clk);
    #1 mdone = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // ==========================================================================
  // Clock and watchdog.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    finish_test;
  end
  // ==========================================================================
  // Main sequence: reset defaults first, then table rows, then identifier and soft reset by hand.
  initial begin
    rst = 1'b1; req = 1'b0; mdone = 1'b0; hum = 14'h0000;
    op = humid_pkg::OP_WRITE_REG; ra = 8'h00; wd = 8'h00;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    chk(alert, 1'b0);
    rd(humid_pkg::REG_HUM_HIGH_TRIGGER_LO, 8'hff);
    rd(humid_pkg::REG_HUM_HIGH_RELEASE_HI, 8'h3f);
    foreach (ROWS[i]) begin
      run(humid_pkg::OP_WRITE_REG, ROWS[i][43:36], ROWS[i][35:28]);
      chk(nack, 1'b0);
      rd(ROWS[i][43:36], ROWS[i][27:20]);
      meas(ROWS[i][17:4]);
      chk(alert, ROWS[i][0]);
    end
    run(humid_pkg::OP_FETCH_ID, 8'h00, 8'h00);
    chk(rdata, ID);
    run(humid_pkg::OP_SOFT_RESET, 8'h00, 8'h00);
    chk(alert, 1'b0);
    rd(humid_pkg::REG_ALERT_POL, 8'h01);
    rd(humid_pkg::REG_HUM_HIGH_TRIGGER_HI, 8'h3f);
    rd(humid_pkg::REG_ALERT_EN, 8'h00);
    // A mid-run reset must restore the idle pin and the default polarity.
    run(humid_pkg::OP_WRITE_REG, humid_pkg::REG_ALERT_POL, 8'h00);
    chk(alert, 1'b1);
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    chk(alert, 1'b0);
    rd(humid_pkg::REG_ALERT_POL, 8'h01);
    finish_test;
  end
endmodule // tb_humid_alert_id_reset_logic
